// ### common/ccas_pkg.sv
package ccas_pkg;
  // ==========================================
  // register map, one aligned word each
  localparam logic [7:0] OFF_CTL1 = 8'h00;
  localparam logic [7:0] OFF_CTL2 = 8'h04;
  localparam logic [7:0] OFF_VAL1_LO = 8'h08;
  localparam logic [7:0] OFF_VAL1_HI = 8'h0C;
  localparam logic [7:0] OFF_VAL2_LO = 8'h10;
  localparam logic [7:0] OFF_VAL2_HI = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  localparam logic [7:0] OFF_COUNT = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MASK = 8'h24;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam int CFG_TMR_ON = 0;
  localparam int CFG_EXT_SRC = 1;
  localparam int CFG_PIN2_SEL = 2;
  localparam int CFG_ADC_EN = 3;
  localparam int ST_CH1 = 0;
  localparam int ST_CH2 = 1;
  localparam int ST_OVF = 2;
  // ==========================================
  // channel_mode_field encodings
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_SET = 4'h8;
  localparam logic [3:0] MODE_CLEAR = 4'h9;
  localparam logic [3:0] MODE_SWINT = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  // ==========================================
  // timing: instruction clock is pclk divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [3:0] CAP_DIV4_LAST = 4'h3;
  localparam logic [3:0] CAP_DIV16_LAST = 4'hF;

  function automatic logic is_compare_mode(input logic [3:0] m);
    return (m == MODE_TOGGLE) || (m[3:2] == 2'h2);
  endfunction

  function automatic logic is_capture_mode(input logic [3:0] m);
    return m[3:2] == 2'h1;
  endfunction

  function automatic logic is_pin_mode(input logic [3:0] m);
    return (m == MODE_TOGGLE) || (m == MODE_SET) || (m == MODE_CLEAR);
  endfunction
endpackage

// ### hdl/ccas_timebase.sv
module ccas_timebase
  import ccas_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic ext_src,
  input wire logic ext_clk_pin,
  input wire logic sleep,
  input wire logic reset_req,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count,
  output logic tick,
  output logic overflow_evt
);
  typedef struct packed {
    logic [1:0] div;
    logic s1;
    logic s2;
    logic prev;
    logic [WIDTH-1:0] count;
  } ccas_tb_t;

  ccas_tb_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = ext_clk_pin;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    // instruction clock stops in sleep, so a count on the internal source holds
    if (!sleep) begin
      st_next.div = 2'(st_reg.div + 2'h1);
    end
    tick = enable && (ext_src ? (st_reg.s2 && !st_reg.prev)
                              : (!sleep && st_reg.div == INSTR_DIV_LAST));
    overflow_evt = tick && !reset_req && (&st_reg.count);
    if (load) begin
      st_next.count = load_value;
    end else if (tick) begin
      // reset_req is sampled live at the tick: a vanished match cancels it
      st_next.count = reset_req ? '0 : WIDTH'(st_reg.count + 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign count = st_reg.count;

  a_reset_at_tick: assert property (@(posedge pclk) disable iff (!presetn)
    tick && reset_req && !load |=> count == '0) else $error("timer not reset at tick");
  a_hold_in_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    sleep && !ext_src && !load |=> $stable(count)) else $error("timer moved in sleep");
  a_no_ovf_trig: assert property (@(posedge pclk) disable iff (!presetn)
    reset_req |-> !overflow_evt) else $error("overflow on trigger reset");
endmodule

// ### hdl/ccas_channel.sv
module ccas_channel
  import ccas_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] mode,
  input wire logic [15:0] value,
  input wire logic [15:0] count,
  input wire logic sleep,
  input wire logic capture_ok,
  input wire logic clear_latch,
  input wire logic pin_sync,
  output logic latch_out,
  output logic drive_en,
  output logic trig,
  output logic flag_evt,
  output logic cap_evt
);
  typedef struct packed {
    logic pin_prev;
    logic match_prev;
    logic latch;
    logic [3:0] presc;
  } ccas_chan_t;

  ccas_chan_t st_reg, st_next;
  logic match, match_rise, edge_seen, presc_last;

  always_comb begin
    st_next = st_reg;
    match = is_compare_mode(mode) && !sleep && (count == value);
    match_rise = match && !st_reg.match_prev;
    trig = match && (mode == MODE_SPECIAL);
    edge_seen = (mode == MODE_CAP_FALL) ? (st_reg.pin_prev && !pin_sync) : (!st_reg.pin_prev && pin_sync);
    presc_last = (mode == MODE_CAP_4) ? (st_reg.presc == CAP_DIV4_LAST) :
                 (mode == MODE_CAP_16) ? (st_reg.presc == CAP_DIV16_LAST) : 1'b1;
    cap_evt = is_capture_mode(mode) && capture_ok && edge_seen && presc_last;
    flag_evt = match_rise || cap_evt;
    st_next.pin_prev = pin_sync;
    st_next.match_prev = match;
    if (!is_capture_mode(mode)) begin
      st_next.presc = '0;
    end else if (capture_ok && edge_seen) begin
      st_next.presc = presc_last ? 4'h0 : 4'(st_reg.presc + 4'h1);
    end
    if (clear_latch) begin
      st_next.latch = 1'b0;
    end else if (match_rise) begin
      // software interrupt and special event leave the latch alone
      if (mode == MODE_TOGGLE) st_next.latch = !st_reg.latch;
      else if (mode == MODE_SET) st_next.latch = 1'b1;
      else if (mode == MODE_CLEAR) st_next.latch = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign latch_out = st_reg.latch;
  assign drive_en = is_pin_mode(mode);

  a_set_on_match: assert property (@(posedge pclk) disable iff (!presetn)
    match_rise && mode == MODE_SET && !clear_latch |=> latch_out) else $error("set action missed");
  a_toggle_match: assert property (@(posedge pclk) disable iff (!presetn)
    match_rise && mode == MODE_TOGGLE && !clear_latch |=> latch_out != $past(latch_out))
    else $error("toggle action missed");
  a_clear_latch_low: assert property (@(posedge pclk) disable iff (!presetn)
    clear_latch |=> !latch_out) else $error("latch not cleared");
  a_sleep_no_trig: assert property (@(posedge pclk) disable iff (!presetn)
    sleep |-> !trig && !(flag_evt && !cap_evt)) else $error("compare active in sleep");
endmodule

// ### hdl/ccas_top.sv
// Implementation choices: the register addresses and the APB slave port.
module ccas_top
  import ccas_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  input wire logic ext_clk_pin,
  output logic irq,
  output logic adc_start,
  output logic special_event,
  input wire logic ch1_pin_in,
  input wire logic ch1_port_data,
  input wire logic ch1_port_dir,
  output logic ch1_pin_out,
  output logic ch1_pin_oe,
  input wire logic pin2a_in,
  input wire logic pin2a_port_data,
  input wire logic pin2a_port_dir,
  output logic pin2a_out,
  output logic pin2a_oe,
  input wire logic pin2b_in,
  input wire logic pin2b_port_data,
  input wire logic pin2b_port_dir,
  output logic pin2b_out,
  output logic pin2b_oe
);
  // ==========================================
  // state
  typedef struct packed {
    logic [5:0] ctl1;
    logic [5:0] ctl2;
    logic [15:0] val1;
    logic [15:0] val2;
    logic [3:0] cfg;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic slverr;
    logic trig2_prev;
    logic p1_s1;
    logic p1_s2;
    logic pa_s1;
    logic pa_s2;
    logic pb_s1;
    logic pb_s2;
  } ccas_top_t;

  ccas_top_t st_reg, st_next;

  logic [15:0] count;
  logic tick, ovf_evt;
  logic trig1, trig2, flag1, flag2, cap1, cap2;
  logic latch1, latch2, drive1, drive2;
  logic clear1, clear2;
  logic load_count;
  logic [15:0] load_value;
  logic wr, wr_lo, wr_hi;
  logic [2:0] st_clear;
  logic [31:0] rd;
  logic mapped;
  logic capture_ok;
  logic pin2_sel;
  logic ch2_pin_sync;

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == OFF_CTL1) || (a == OFF_CTL2) || (a == OFF_VAL1_LO) || (a == OFF_VAL1_HI) ||
           (a == OFF_VAL2_LO) || (a == OFF_VAL2_HI) || (a == OFF_CFG) || (a == OFF_COUNT) ||
           (a == OFF_STATUS) || (a == OFF_MASK);
  endfunction

  // ==========================================
  // timebase and channels
  ccas_timebase #(
    .WIDTH(16)
  ) u_timebase (
    .pclk(pclk),
    .presetn(presetn),
    .enable(st_reg.cfg[CFG_TMR_ON]),
    .ext_src(st_reg.cfg[CFG_EXT_SRC]),
    .ext_clk_pin(ext_clk_pin),
    .sleep(sleep),
    .reset_req(trig1 || trig2),
    .load(load_count),
    .load_value(load_value),
    .count(count),
    .tick(tick),
    .overflow_evt(ovf_evt)
  );

  ccas_channel u_ch1 (
    .pclk(pclk),
    .presetn(presetn),
    .mode(st_reg.ctl1[3:0]),
    .value(st_reg.val1),
    .count(count),
    .sleep(sleep),
    .capture_ok(capture_ok),
    .clear_latch(clear1),
    .pin_sync(st_reg.p1_s2),
    .latch_out(latch1),
    .drive_en(drive1),
    .trig(trig1),
    .flag_evt(flag1),
    .cap_evt(cap1)
  );

  ccas_channel u_ch2 (
    .pclk(pclk),
    .presetn(presetn),
    .mode(st_reg.ctl2[3:0]),
    .value(st_reg.val2),
    .count(count),
    .sleep(sleep),
    .capture_ok(capture_ok),
    .clear_latch(clear2),
    .pin_sync(ch2_pin_sync),
    .latch_out(latch2),
    .drive_en(drive2),
    .trig(trig2),
    .flag_evt(flag2),
    .cap_evt(cap2)
  );

  // ==========================================
  // next state
  always_comb begin
    st_next = st_reg;
    // every pin input is synchronised before the channel looks at it
    st_next.p1_s1 = ch1_pin_in;
    st_next.p1_s2 = st_reg.p1_s1;
    st_next.pa_s1 = pin2a_in;
    st_next.pa_s2 = st_reg.pa_s1;
    st_next.pb_s1 = pin2b_in;
    st_next.pb_s2 = st_reg.pb_s1;
    st_next.trig2_prev = trig2;

    wr = psel && penable && pwrite && !st_reg.slverr;
    wr_lo = wr && pstrb[0];
    wr_hi = wr && pstrb[1];

    // a whole-register zero write drops the compare latch
    clear1 = wr_lo && (paddr == OFF_CTL1) && (pwdata[7:0] == 8'h00);
    clear2 = wr_lo && (paddr == OFF_CTL2) && (pwdata[7:0] == 8'h00);

    load_count = (wr_lo || wr_hi) && (paddr == OFF_COUNT);
    load_value = {wr_hi ? pwdata[15:8] : count[15:8], wr_lo ? pwdata[7:0] : count[7:0]};

    if (wr_lo) begin
      unique case (paddr)
        OFF_CTL1: st_next.ctl1 = pwdata[5:0];
        OFF_CTL2: st_next.ctl2 = pwdata[5:0];
        OFF_VAL1_LO: st_next.val1[7:0] = pwdata[7:0];
        OFF_VAL1_HI: st_next.val1[15:8] = pwdata[7:0];
        OFF_VAL2_LO: st_next.val2[7:0] = pwdata[7:0];
        OFF_VAL2_HI: st_next.val2[15:8] = pwdata[7:0];
        OFF_CFG: st_next.cfg = pwdata[3:0];
        OFF_MASK: st_next.mask = pwdata[2:0];
        default: ;
      endcase
    end

    // a capture overwrites any value not yet read
    if (cap1) st_next.val1 = count;
    if (cap2) st_next.val2 = count;

    // write-one-to-clear; a same-cycle event wins over the clear
    st_clear = (wr_lo && paddr == OFF_STATUS) ? pwdata[2:0] : 3'h0;
    st_next.status = (st_reg.status & ~st_clear) | {ovf_evt && tick, flag2, flag1};

    rd = 32'h0000_0000;
    unique case (paddr)
      OFF_CTL1: rd[5:0] = st_reg.ctl1;
      OFF_CTL2: rd[5:0] = st_reg.ctl2;
      OFF_VAL1_LO: rd[7:0] = st_reg.val1[7:0];
      OFF_VAL1_HI: rd[7:0] = st_reg.val1[15:8];
      OFF_VAL2_LO: rd[7:0] = st_reg.val2[7:0];
      OFF_VAL2_HI: rd[7:0] = st_reg.val2[15:8];
      OFF_CFG: rd[3:0] = st_reg.cfg;
      OFF_COUNT: rd[15:0] = count;
      OFF_STATUS: rd[2:0] = st_reg.status;
      OFF_MASK: rd[2:0] = st_reg.mask;
      default: ;
    endcase
    mapped = addr_mapped(paddr);

    // read data and error are fixed in the setup cycle so the access phase is one cycle
    if (psel && !penable) begin
      st_next.rdata = pwrite ? 32'h0000_0000 : rd;
      st_next.slverr = !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctl1 <= CTL_RESET;
      st_reg.ctl2 <= CTL_RESET;
      st_reg.cfg <= CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // outputs
  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = st_reg.slverr;
  assign irq = |(st_reg.status & st_reg.mask);
  assign special_event = trig1 || trig2;
  // capture in sleep only runs when the timebase has its own clock
  assign capture_ok = !sleep || st_reg.cfg[CFG_EXT_SRC];
  assign adc_start = trig2 && !st_reg.trig2_prev && st_reg.cfg[CFG_ADC_EN];
  assign pin2_sel = st_reg.cfg[CFG_PIN2_SEL];
  assign ch2_pin_sync = pin2_sel ? st_reg.pb_s2 : st_reg.pa_s2;

  // the port direction bit owns the driver; the compare latch only replaces the port data
  assign ch1_pin_out = drive1 ? latch1 : ch1_port_data;
  assign ch1_pin_oe = !ch1_port_dir;
  assign pin2a_out = (drive2 && !pin2_sel) ? latch2 : pin2a_port_data;
  assign pin2a_oe = !pin2a_port_dir;
  assign pin2b_out = (drive2 && pin2_sel) ? latch2 : pin2b_port_data;
  assign pin2b_oe = !pin2b_port_dir;

  // ==========================================
  // checks
  a_swint_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.ctl1[3:0] == MODE_SWINT |-> ch1_pin_out == ch1_port_data)
    else $error("software interrupt mode drove the pin");
  a_special_no_pin: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.ctl2[3:0] == MODE_SPECIAL |-> pin2a_out == pin2a_port_data && pin2b_out == pin2b_port_data)
    else $error("special event mode drove the pin");
  a_flag_on_event: assert property (@(posedge pclk) disable iff (!presetn)
    flag1 |=> st_reg.status[ST_CH1]) else $error("channel flag not set");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.status[ST_CH2] && !(wr_lo && paddr == OFF_STATUS && pwdata[ST_CH2]) |=> st_reg.status[ST_CH2])
    else $error("channel flag lost without clear");
  a_adc_start_ch2: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(trig2) && st_reg.cfg[CFG_ADC_EN] |-> adc_start) else $error("conversion not started");
  a_adc_only_ch2: assert property (@(posedge pclk) disable iff (!presetn)
    adc_start |-> trig2) else $error("conversion start without channel 2 trigger");
  a_pin2_route: assert property (@(posedge pclk) disable iff (!presetn)
    pin2_sel |-> pin2a_out == pin2a_port_data) else $error("unselected pin driven by channel");
  // either channel's trigger restarts the shared timebase; a sticky overflow flag from before is allowed
  a_period_reset: assert property (@(posedge pclk) disable iff (!presetn)
    special_event && tick && !load_count |=>
      count == 16'h0000 && (!st_reg.status[ST_OVF] || $past(st_reg.status[ST_OVF])))
    else $error("trigger did not restart timebase");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    flag1 && st_reg.mask[ST_CH1] && !(wr_lo && paddr == OFF_MASK) |=> irq)
    else $error("interrupt not raised");
  a_count_load: assert property (@(posedge pclk) disable iff (!presetn)
    load_count |=> count == $past(load_value)) else $error("count write not loaded");
  a_capture_loads: assert property (@(posedge pclk) disable iff (!presetn)
    cap1 |=> st_reg.val1 == $past(count)) else $error("capture did not latch the count");
  a_status_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    wr_lo && paddr == OFF_STATUS && pwdata[ST_CH1] && !flag1 |=> !st_reg.status[ST_CH1])
    else $error("status bit not cleared");
  a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pslverr) else $error("unmapped access without error");
  a_special_ch1_pin: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.ctl1[3:0] == MODE_SPECIAL |-> ch1_pin_out == ch1_port_data)
    else $error("special event mode drove channel 1 pin");
  a_adc_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
    adc_start |-> st_reg.cfg[CFG_ADC_EN]) else $error("conversion started while disabled");

  c_period_reset: cover property (@(posedge pclk) disable iff (!presetn) special_event && tick);
  c_sleep_capture: cover property (@(posedge pclk) disable iff (!presetn) cap1 && sleep);
  c_capture: cover property (@(posedge pclk) disable iff (!presetn) cap1);
  c_adc_start: cover property (@(posedge pclk) disable iff (!presetn) adc_start);
  c_toggle_pin: cover property (@(posedge pclk) disable iff (!presetn)
    flag1 && st_reg.ctl1[3:0] == MODE_TOGGLE);
endmodule

// ### verif/ccas_far_end.sv
module ccas_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ch1_pin_out,
  input wire logic ch1_pin_oe,
  input wire logic pin2a_out,
  input wire logic pin2a_oe,
  input wire logic pin2b_out,
  input wire logic pin2b_oe,
  input wire logic [2:0] ext_lvl,
  input wire logic adc_start,
  output logic ch1_pin_in,
  output logic pin2a_in,
  output logic pin2b_in,
  output logic [7:0] adc_starts
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // pin wires: a driving pin wins, otherwise the outside world sets the level
  assign ch1_pin_in = ch1_pin_oe ? ch1_pin_out : ext_lvl[0];
  assign pin2a_in = pin2a_oe ? pin2a_out : ext_lvl[1];
  assign pin2b_in = pin2b_oe ? pin2b_out : ext_lvl[2];
  // ==========================================
  // converter side: counts starts so a missed or doubled pulse shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_starts <= 8'h00;
    end else if (adc_start) begin
      adc_starts <= adc_starts + 8'h01;
    end
  end
endmodule

// ### verif/tb_ccas_top.sv
module tb_ccas_top
  import ccas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleep = 1'b0, ext_clk_pin = 1'b0, pready, pslverr, irq, adc_start, special_event, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, c;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] port_data = 3'h0, port_dir = 3'h7, ext_lvl = 3'h0;
  logic ch1_pin_in, ch1_pin_out, ch1_pin_oe, pin2a_in, pin2a_out, pin2a_oe, pin2b_in, pin2b_out, pin2b_oe;
  logic [7:0] adc_starts;
  logic [3:0] modes [4] = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_SWINT};
  logic pins [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] rsts [5] = '{OFF_CTL1, OFF_CTL2, OFF_CFG, OFF_STATUS, OFF_MASK};
  int fails = 0, n_compared = 0, k;

  always #25 pclk = ~pclk;

  ccas_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep(sleep), .ext_clk_pin(ext_clk_pin), .irq(irq), .adc_start(adc_start), .special_event(special_event),
    .ch1_pin_in(ch1_pin_in), .ch1_port_data(port_data[0]), .ch1_port_dir(port_dir[0]),
    .ch1_pin_out(ch1_pin_out), .ch1_pin_oe(ch1_pin_oe), .pin2a_in(pin2a_in), .pin2a_port_data(port_data[1]),
    .pin2a_port_dir(port_dir[1]), .pin2a_out(pin2a_out), .pin2a_oe(pin2a_oe), .pin2b_in(pin2b_in),
    .pin2b_port_data(port_data[2]), .pin2b_port_dir(port_dir[2]), .pin2b_out(pin2b_out), .pin2b_oe(pin2b_oe));

  ccas_far_end far (.pclk(pclk), .presetn(presetn), .ch1_pin_out(ch1_pin_out), .ch1_pin_oe(ch1_pin_oe),
    .pin2a_out(pin2a_out), .pin2a_oe(pin2a_oe), .pin2b_out(pin2b_out), .pin2b_oe(pin2b_oe),
    .ext_lvl(ext_lvl), .adc_start(adc_start), .ch1_pin_in(ch1_pin_in), .pin2a_in(pin2a_in),
    .pin2b_in(pin2b_in), .adc_starts(adc_starts));

  // ==========================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================
  // bus access; an idle edge first so psel never toggles within one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      test_done;
    end
  endtask

  // sel 0 waits for irq, sel 1 for the special event output
  task automatic wait_for(input int sel, input int lim);
    int n;
    n = 0;
    // look just after the edge so an update made at that edge is already seen
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (!(sel == 0 ? irq === 1'b1 : special_event === 1'b1) && n < lim);
    if (!(sel == 0 ? irq === 1'b1 : special_event === 1'b1)) begin
      fails++;
      test_done;
    end
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rsts[i]) begin
      apb(0, rsts[i], 0);
      chk("reset value", 32'h0, rd);
    end
    apb(0, 8'h28, 0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1, OFF_CTL1, 32'hFF);
    apb(0, OFF_CTL1, 0);
    chk("control width", 32'h3F, rd);
    port_dir <= 3'h0;
    apb(1, OFF_MASK, 32'h1);
    apb(1, OFF_CFG, 32'h1);
    apb(1, OFF_VAL1_LO, 32'h05);
    apb(1, OFF_VAL1_HI, 32'h01);
    apb(1, OFF_CTL1, {28'h0, MODE_SWINT});
    apb(1, OFF_COUNT, 32'h0);
    apb(1, OFF_STATUS, 32'h7);
    repeat (60) @(posedge pclk);
    apb(0, OFF_STATUS, 0);
    chk("low byte only", 32'h0, rd);
    foreach (modes[i]) begin
      apb(1, OFF_CTL1, {28'h0, modes[i]});
      apb(1, OFF_COUNT, 32'h0100);
      apb(1, OFF_STATUS, 32'h7);
      wait_for(0, 200);
      @(posedge pclk);
      #1;
      chk("ch1 pin", {31'h0, pins[i]}, {31'h0, ch1_pin_out});
      chk("ch1 oe", 32'h1, {31'h0, ch1_pin_oe});
    end
    apb(1, OFF_MASK, 32'h0);
    #1;
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(0, OFF_STATUS, 0);
    chk("sticky flag", 32'h1, rd & 32'h1);
    apb(1, OFF_STATUS, 32'h1);
    apb(0, OFF_STATUS, 0);
    chk("flag cleared", 32'h0, rd);
    // zero write drops the latch; the port latch at 1 must not leak through
    apb(1, OFF_CTL1, 32'h0);
    port_data <= 3'h1;
    apb(1, OFF_CTL1, {28'h0, MODE_TOGGLE});
    #1;
    chk("latch cleared", 32'h0, {31'h0, ch1_pin_out});
    apb(1, OFF_MASK, 32'h2);
    apb(1, OFF_CFG, 32'hD);
    apb(1, OFF_VAL2_LO, 32'h08);
    apb(1, OFF_VAL2_HI, 32'h00);
    apb(1, OFF_CTL2, {28'h0, MODE_SPECIAL});
    apb(1, OFF_COUNT, 32'h0);
    apb(1, OFF_STATUS, 32'h7);
    wait_for(1, 200);
    chk("adc same cycle", 32'h1, {31'h0, adc_start});
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (special_event === 1'b1 && k < 200);
    while (special_event !== 1'b1 && k < 200) begin
      @(posedge pclk);
      #1;
      k++;
    end
    chk("trigger period", 32'd36, k);
    // the converter model counts the pulse at the following edge
    @(posedge pclk);
    #1;
    chk("adc starts", 32'h2, {24'h0, adc_starts});
    apb(0, OFF_STATUS, 0);
    chk("no overflow flag", 32'h2, rd & 32'h6);
    apb(1, OFF_CTL2, {28'h0, MODE_SET});
    apb(1, OFF_COUNT, 32'h0);
    apb(1, OFF_STATUS, 32'h7);
    wait_for(0, 200);
    @(posedge pclk);
    #1;
    chk("alt pin driven", 32'h1, {31'h0, pin2b_out});
    chk("main pin port", 32'h0, {31'h0, pin2a_out});
    chk("pin2 oe", 32'h3, {30'h0, pin2b_oe, pin2a_oe});
    apb(1, OFF_CTL1, {28'h0, MODE_SWINT});
    apb(1, OFF_CFG, 32'h3);
    sleep <= 1'b1;
    apb(1, OFF_COUNT, 32'h0105);
    apb(1, OFF_STATUS, 32'h7);
    apb(1, OFF_CFG, 32'h1);
    repeat (20) @(posedge pclk);
    apb(0, OFF_STATUS, 0);
    chk("no compare asleep", 32'h0, rd & 32'h1);
    apb(0, OFF_COUNT, 0);
    chk("count held", 32'h0105, rd);
    @(posedge pclk);
    sleep <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(0, OFF_STATUS, 0);
    chk("match after wake", 32'h1, rd & 32'h1);
    apb(0, OFF_COUNT, 0);
    chk("count resumed", 32'h1, {31'h0, rd > 32'h0105 && rd < 32'h0110});
    // capture on a rising then a falling pin edge while asleep, external clock source
    port_dir <= 3'h7;
    ext_lvl <= 3'h0;
    apb(1, OFF_CTL1, 32'h5);
    apb(1, OFF_CFG, 32'h3);
    apb(1, OFF_STATUS, 32'h7);
    sleep <= 1'b1;
    apb(0, OFF_COUNT, 0);
    c = rd;
    repeat (6) begin
      @(posedge pclk) ext_clk_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_clk_pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    apb(0, OFF_COUNT, 0);
    chk("ext count asleep", c + 32'd6, rd);
    c = rd;
    ext_lvl <= 3'h1;
    repeat (8) @(posedge pclk);
    apb(0, OFF_STATUS, 0);
    chk("capture flag", 32'h1, rd & 32'h1);
    apb(0, OFF_VAL1_LO, 0);
    chk("captured low", c & 32'hFF, rd);
    apb(0, OFF_VAL1_HI, 0);
    chk("captured high", (c >> 8) & 32'hFF, rd);
    apb(1, OFF_CTL1, {28'h0, MODE_CAP_FALL});
    apb(1, OFF_STATUS, 32'h7);
    ext_lvl <= 3'h0;
    repeat (8) @(posedge pclk);
    apb(0, OFF_STATUS, 0);
    chk("falling capture flag", 32'h1, rd & 32'h1);
    sleep <= 1'b0;
    test_done;
  end
endmodule
